// ===== astc_pkg.sv
package astc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] WRAP_CHANNEL_CTRL_ADDR       = 8'h00;
    localparam logic [7:0] RESOLUTION_TRIGGER_CTRL_ADDR = 8'h04;
    localparam logic [7:0] SEQ_CTRL_ADDR                = 8'h08;
    localparam logic [7:0] SEQ_STATUS_ADDR              = 8'h0C;

    localparam logic [7:0] WRAP_CHANNEL_CTRL_RESET       = 8'h00;
    localparam logic [7:0] RESOLUTION_TRIGGER_CTRL_RESET = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int WRAP_LSB        = 0;
    localparam int DISCHARGE_BIT   = 4;
    localparam int RES_LSB         = 5;
    localparam int TRIG_KIND_BIT   = 7;
    localparam int TRIG_CH_LSB     = 0;
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_MULTI_BIT  = 1;

    // ************************************************************
    // Encodings and counts
    // ************************************************************
    localparam logic [3:0] LAST_CHANNEL      = 4'h9;
    localparam logic [1:0] RES_8BIT          = 2'h0;
    localparam logic [1:0] RES_10BIT         = 2'h1;
    localparam logic [1:0] RES_12BIT         = 2'h2;
    localparam logic [3:0] RESULT_BITS_8     = 4'h8;
    localparam logic [3:0] RESULT_BITS_10    = 4'hA;
    localparam logic [3:0] RESULT_BITS_12    = 4'hC;
    localparam logic [3:0] SAMPLE_CYCLES     = 4'h4;
    localparam logic [3:0] DISCHARGE_CYCLES  = 4'h2;
    localparam logic [3:0] CONV_CLK_DIV      = 4'h2;

    typedef enum logic [1:0] {
        AXI_OKAY   = 2'h0,
        AXI_SLVERR = 2'h2
    } astc_resp_type;

    typedef struct packed {
        logic [3:0] wrap;
        logic       discharge;
        logic [1:0] res;
        logic       trig_kind;
        logic [3:0] trig_ch;
        logic       multi;
    } astc_cfg_type;

endpackage

// ===== astc_conv_tick.sv
`timescale 1ns/1ps
module astc_conv_tick (
    input  wire logic aclk,      // Module clock.
    input  wire logic aresetn,   // Synchronous reset, active low.
    output logic      tick       // One-cycle conversion clock enable.
);

    logic [3:0] cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 4'h0;
            tick  <= 1'b0;
        end else if (cnt_q == astc_pkg::CONV_CLK_DIV - 4'h1) begin
            cnt_q <= 4'h0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            tick  <= 1'b0;
        end
    end

endmodule // astc_conv_tick

// ===== astc_sync2.sv
`timescale 1ns/1ps
module astc_sync2 #(
    parameter int WIDTH = 4
) (
    input  wire logic             aclk,     // Module clock.
    input  wire logic             aresetn,  // Synchronous reset, active low.
    input  wire logic [WIDTH-1:0] din,      // Asynchronous inputs.
    output logic      [WIDTH-1:0] dout      // Synchronised copy.
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule // astc_sync2

// ===== astc_top.sv
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module astc_top #(
    parameter bit HAS_DEDICATED = 1'b1
) (
    input  wire logic        aclk,          // Module clock, 25 MHz.
    input  wire logic        aresetn,       // Synchronous reset, active low.
    input  wire logic [7:0]  s_axi_awaddr,  // Write address.
    input  wire logic        s_axi_awvalid, // Write address valid.
    output logic             s_axi_awready, // Write address ready.
    input  wire logic [31:0] s_axi_wdata,   // Write data.
    input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes.
    input  wire logic        s_axi_wvalid,  // Write data valid.
    output logic             s_axi_wready,  // Write data ready.
    output logic [1:0]       s_axi_bresp,   // Write response.
    output logic             s_axi_bvalid,  // Write response valid.
    input  wire logic        s_axi_bready,  // Write response ready.
    input  wire logic [7:0]  s_axi_araddr,  // Read address.
    input  wire logic        s_axi_arvalid, // Read address valid.
    output logic             s_axi_arready, // Read address ready.
    output logic [31:0]      s_axi_rdata,   // Read data.
    output logic [1:0]       s_axi_rresp,   // Read response.
    output logic             s_axi_rvalid,  // Read data valid.
    input  wire logic        s_axi_rready,  // Read data ready.
    input  wire logic [9:0]  analog_trig,   // Analog channel trigger levels.
    input  wire logic [3:0]  dedicated_trigger_inputs, // Trigger pins.
    output logic [3:0]       cur_channel,   // Channel being converted.
    output logic [3:0]       result_bits,   // Result width in bits.
    output logic             sampling,      // Sample phase active.
    output logic             discharging,   // Sample capacitor discharge.
    output logic             seq_busy,      // Sequence in progress.
    output logic             seq_aborted,   // Pulse when a sequence aborts.
    output logic             trigger_event  // Pulse on selected trigger edge.
);

    // ************************************************************
    // Registers and synchronisers
    // ************************************************************
    logic [7:0] wrap_channel_ctrl_q;
    logic [7:0] resolution_trigger_ctrl_q;
    logic       multi_channel_select_q;
    logic       aw_held_q, w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic       wr_cfg_hit;
    logic       wr_do;
    logic       start_req;
    logic       conv_tick;
    logic [9:0] analog_sync;
    logic [3:0] dedicated_sync;
    logic       trig_level, trig_level_q;
    logic       trig_allowed;
    astc_pkg::astc_cfg_type cfg;

    astc_conv_tick u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (conv_tick)
    );

    astc_sync2 #(.WIDTH(10)) u_sync_an (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (analog_trig),
        .dout    (analog_sync)
    );

    astc_sync2 #(.WIDTH(4)) u_sync_ded (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (dedicated_trigger_inputs),
        .dout    (dedicated_sync)
    );

    assign cfg.wrap      = wrap_channel_ctrl_q[astc_pkg::WRAP_LSB +: 4];
    assign cfg.discharge =
        resolution_trigger_ctrl_q[astc_pkg::DISCHARGE_BIT];
    assign cfg.res       = resolution_trigger_ctrl_q[astc_pkg::RES_LSB +: 2];
    assign cfg.trig_kind =
        resolution_trigger_ctrl_q[astc_pkg::TRIG_KIND_BIT];
    assign cfg.trig_ch   =
        resolution_trigger_ctrl_q[astc_pkg::TRIG_CH_LSB +: 4];
    assign cfg.multi     = multi_channel_select_q;

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    // Address and data are latched independently so either may come first.
    assign wr_do = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            aw_addr_q     <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_do) begin
            aw_held_q     <= 1'b0;
        end else if (!aw_held_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q     <= 1'b0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_do) begin
            w_held_q     <= 1'b0;
        end else if (!w_held_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= astc_pkg::AXI_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr_q[7:2])
                astc_pkg::WRAP_CHANNEL_CTRL_ADDR[7:2],
                astc_pkg::RESOLUTION_TRIGGER_CTRL_ADDR[7:2],
                astc_pkg::SEQ_CTRL_ADDR[7:2],
                astc_pkg::SEQ_STATUS_ADDR[7:2]:
                    s_axi_bresp <= astc_pkg::AXI_OKAY;
                default:
                    s_axi_bresp <= astc_pkg::AXI_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Any write to a configuration word aborts, even with no byte lanes.
    assign wr_cfg_hit = wr_do &&
        (aw_addr_q[7:2] == astc_pkg::WRAP_CHANNEL_CTRL_ADDR[7:2] ||
         aw_addr_q[7:2] == astc_pkg::RESOLUTION_TRIGGER_CTRL_ADDR[7:2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_channel_ctrl_q       <= astc_pkg::WRAP_CHANNEL_CTRL_RESET;
            resolution_trigger_ctrl_q <=
                astc_pkg::RESOLUTION_TRIGGER_CTRL_RESET;
        end else if (wr_do && w_strb_q[0]) begin
            // Every bit is stored as written, reserved codes included.
            if (aw_addr_q[7:2] == astc_pkg::WRAP_CHANNEL_CTRL_ADDR[7:2])
                wrap_channel_ctrl_q <= w_data_q[7:0];
            if (aw_addr_q[7:2] == astc_pkg::RESOLUTION_TRIGGER_CTRL_ADDR[7:2])
                resolution_trigger_ctrl_q <= w_data_q[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            multi_channel_select_q <= 1'b0;
            start_req              <= 1'b0;
        end else begin
            start_req <= 1'b0;
            if (wr_do && w_strb_q[0] &&
                aw_addr_q[7:2] == astc_pkg::SEQ_CTRL_ADDR[7:2]) begin
                multi_channel_select_q <=
                    w_data_q[astc_pkg::CTRL_MULTI_BIT];
                start_req <= w_data_q[astc_pkg::CTRL_START_BIT];
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= astc_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= astc_pkg::AXI_OKAY;
            case (s_axi_araddr[7:2])
                astc_pkg::WRAP_CHANNEL_CTRL_ADDR[7:2]:
                    s_axi_rdata <= {24'h00_0000, wrap_channel_ctrl_q};
                astc_pkg::RESOLUTION_TRIGGER_CTRL_ADDR[7:2]:
                    s_axi_rdata <= {24'h00_0000,
                                    resolution_trigger_ctrl_q};
                astc_pkg::SEQ_CTRL_ADDR[7:2]:
                    s_axi_rdata <= {30'h0,
                                    multi_channel_select_q, 1'b0};
                astc_pkg::SEQ_STATUS_ADDR[7:2]:
                    s_axi_rdata <= {26'h0, cur_channel,
                                    sampling, seq_busy};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= astc_pkg::AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ************************************************************
    // Trigger source selection
    // ************************************************************
    always_comb begin
        trig_allowed = 1'b1;
        trig_level   = 1'b0;
        if (cfg.trig_kind && HAS_DEDICATED) begin
            // Codes with bit 2 or 3 set select nothing.
            trig_allowed = (cfg.trig_ch[3:2] == 2'b00);
            trig_level   = dedicated_sync[cfg.trig_ch[1:0]];
        end else if (cfg.trig_ch > astc_pkg::LAST_CHANNEL) begin
            trig_level = analog_sync[astc_pkg::LAST_CHANNEL];
        end else begin
            trig_level = analog_sync[cfg.trig_ch];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_level_q  <= 1'b0;
            trigger_event <= 1'b0;
        end else begin
            trig_level_q  <= trig_level;
            trigger_event <= trig_allowed && trig_level && !trig_level_q;
        end
    end

    // ************************************************************
    // Conversion sequencer
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DISCHARGE,
        ST_SAMPLE,
        ST_CONVERT
    } astc_state_type;

    astc_state_type state_q;
    logic [3:0]     phase_cnt_q;
    logic [3:0]     wrap_last;

    // Wrap value zero is reserved and simply acts as channel zero here.
    assign wrap_last = (cfg.wrap > astc_pkg::LAST_CHANNEL) ?
                       astc_pkg::LAST_CHANNEL : cfg.wrap;

    // Registered so the port comes from a flop; it lags a write by a cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_bits <= astc_pkg::RESULT_BITS_8;
        end else begin
            case (cfg.res)
                astc_pkg::RES_8BIT:  result_bits <= astc_pkg::RESULT_BITS_8;
                astc_pkg::RES_10BIT: result_bits <= astc_pkg::RESULT_BITS_10;
                astc_pkg::RES_12BIT: result_bits <= astc_pkg::RESULT_BITS_12;
                default:             result_bits <= astc_pkg::RESULT_BITS_12;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= ST_IDLE;
            phase_cnt_q <= 4'h0;
            cur_channel <= 4'h0;
            seq_busy    <= 1'b0;
            sampling    <= 1'b0;
            discharging <= 1'b0;
            seq_aborted <= 1'b0;
        end else if (wr_cfg_hit) begin
            seq_aborted <= seq_busy;
            state_q     <= ST_IDLE;
            seq_busy    <= 1'b0;
            sampling    <= 1'b0;
            discharging <= 1'b0;
            cur_channel <= 4'h0;
        end else begin
            seq_aborted <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_req || trigger_event) begin
                        seq_busy    <= 1'b1;
                        cur_channel <= 4'h0;
                        phase_cnt_q <= 4'h0;
                        if (cfg.discharge) begin
                            state_q     <= ST_DISCHARGE;
                            discharging <= 1'b1;
                        end else begin
                            state_q  <= ST_SAMPLE;
                            sampling <= 1'b1;
                        end
                    end
                end
                ST_DISCHARGE: if (conv_tick) begin
                    if (phase_cnt_q == astc_pkg::DISCHARGE_CYCLES - 4'h1) begin
                        phase_cnt_q <= 4'h0;
                        discharging <= 1'b0;
                        sampling    <= 1'b1;
                        state_q     <= ST_SAMPLE;
                    end else begin
                        phase_cnt_q <= phase_cnt_q + 4'h1;
                    end
                end
                ST_SAMPLE: if (conv_tick) begin
                    if (phase_cnt_q == astc_pkg::SAMPLE_CYCLES - 4'h1) begin
                        phase_cnt_q <= 4'h0;
                        sampling    <= 1'b0;
                        state_q     <= ST_CONVERT;
                    end else begin
                        phase_cnt_q <= phase_cnt_q + 4'h1;
                    end
                end
                ST_CONVERT: if (conv_tick) begin
                    if (phase_cnt_q == result_bits - 4'h1) begin
                        phase_cnt_q <= 4'h0;
                        if (cfg.multi && cur_channel < wrap_last) begin
                            cur_channel <= cur_channel + 4'h1;
                        end else begin
                            cur_channel <= 4'h0;
                        end
                        if (cfg.multi && cur_channel < wrap_last) begin
                            if (cfg.discharge) begin
                                state_q     <= ST_DISCHARGE;
                                discharging <= 1'b1;
                            end else begin
                                state_q  <= ST_SAMPLE;
                                sampling <= 1'b1;
                            end
                        end else begin
                            state_q  <= ST_IDLE;
                            seq_busy <= 1'b0;
                        end
                    end else begin
                        phase_cnt_q <= phase_cnt_q + 4'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // astc_top

// ===== astc_checker.sv
`timescale 1ns/1ps
module astc_checker #(
    parameter bit HAS_DEDICATED = 1'b1
) (
    input wire logic        aclk,          // Clock.
    input wire logic        aresetn,       // Reset.
    input wire logic [7:0]  s_axi_awaddr,  // Bus.
    input wire logic        s_axi_awvalid, // Bus.
    input wire logic        s_axi_awready, // Bus.
    input wire logic [31:0] s_axi_wdata,   // Bus.
    input wire logic        s_axi_wvalid,  // Bus.
    input wire logic        s_axi_wready,  // Bus.
    input wire logic        s_axi_bvalid,  // Bus.
    input wire logic        s_axi_bready,  // Bus.
    input wire logic [7:0]  s_axi_araddr,  // Bus.
    input wire logic        s_axi_arvalid, // Bus.
    input wire logic        s_axi_arready, // Bus.
    input wire logic [31:0] s_axi_rdata,   // Bus.
    input wire logic [1:0]  s_axi_rresp,   // Bus.
    input wire logic        s_axi_rvalid,  // Bus.
    input wire logic [3:0]  cur_channel,   // Channel.
    input wire logic [3:0]  result_bits,   // Width.
    input wire logic        discharging,   // Discharge.
    input wire logic        seq_busy,      // Busy.
    input wire logic        seq_aborted,   // Abort.
    input wire logic        trigger_event  // Trigger.
);
    // ************************************************************
    // Shadow registers
    // ************************************************************
    // The shadows assume address and data are taken at one edge.
    logic       wr_hs;
    logic [7:0] wrap_q;
    logic [7:0] rt_q;
    logic [3:0] wrap_eff;
    logic [3:0] res_exp;
    logic       rsv;

    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                   && s_axi_wready;
    assign wrap_eff = (wrap_q[3:0] > 4'h9) ? 4'h9 : wrap_q[3:0];
    assign res_exp = (rt_q[6:5] == 2'h0) ? 4'h8
                   : (rt_q[6:5] == 2'h1) ? 4'hA : 4'hC;
    assign rsv = HAS_DEDICATED && rt_q[7] && (rt_q[3:2] != 2'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_q <= 8'h00;
        end else if (wr_hs && s_axi_awaddr == 8'h00) begin
            wrap_q <= s_axi_wdata[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rt_q <= 8'h00;
        end else if (wr_hs && s_axi_awaddr == 8'h04) begin
            rt_q <= s_axi_wdata[7:0];
        end
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_ABORT: assert property (
        wr_hs && s_axi_awaddr[7:3] == 5'h0 ##1 seq_busy
        |=> seq_aborted) else $error("no abort on config write");
    AST_ABORT_IDLE: assert property (
        seq_aborted |-> ##[0:1] !seq_busy) else $error("busy after abort");
    AST_RES: assert property (
        result_bits == $past(res_exp, 2)) else $error("result width wrong");
    AST_WRAP: assert property (
        seq_busy && $stable(wrap_q) |-> cur_channel <= wrap_eff)
        else $error("channel beyond wrap point");
    AST_DIS: assert property (
        discharging |-> rt_q[4] || $past(wr_hs))
        else $error("discharge while disabled");
    AST_DIS_LEN: assert property (
        $rose(discharging) |-> (discharging[*3] ##[1:2] !discharging)
        or (##[1:5] seq_aborted)) else $error("discharge length wrong");
    AST_TRIG: assert property (
        trigger_event |-> ##[0:2] seq_busy) else $error("trigger idle");
    AST_RSV: assert property (
        rsv && $past(rsv, 3) |-> !trigger_event)
        else $error("reserved code fired");
    AST_BHOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_UNMAP: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] != 4'h0
        |-> ##[1:2] (s_axi_rvalid && s_axi_rdata == 32'h0
        && s_axi_rresp == astc_pkg::AXI_SLVERR))
        else $error("unmapped read answer wrong");

    cover property (seq_aborted);
    cover property (trigger_event);
    cover property ($rose(discharging));
endmodule // astc_checker

// ===== astc_top_test.sv
`timescale 1ns/1ps
module astc_top_test;
    localparam logic [1:0] OK = astc_pkg::AXI_OKAY;
    localparam logic [1:0] ER = astc_pkg::AXI_SLVERR;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sampling;
    logic        discharging, seq_busy, seq_aborted, trigger_event;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, dedicated_trigger_inputs;
    logic [3:0]  cur_channel, result_bits;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [9:0]  analog_trig;
    int          err_count, comparisons, aborts;

    astc_top uut (.*);

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic end_sim();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tmo();
        err_count++;
        $display("BAD t=%0t timeout got=%h exp=%h", $time, 0, 1);
        end_sim();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) tmo();
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        if (n >= 50) tmo();
        chk(s_axi_rdata, d);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask

    task automatic watch(output logic s);
        s = 1'b0;
        repeat (10) begin
            @(posedge aclk);
            if (trigger_event === 1'b1) s = 1'b1;
        end
    endtask

    function automatic logic [31:0] res_of(input logic [1:0] c);
        return (c == 2'h0) ? 32'h8 : (c == 2'h1) ? 32'hA : 32'hC;
    endfunction

    // Bit index into {dedicated, analog}; 14 means no source fires.
    function automatic int src_of(input logic [7:0] c);
        if (!c[7]) return (c[3:0] > 4'h9) ? 9 : int'(c[3:0]);
        if (c[3:2] == 2'h0) return 10 + int'(c[1:0]);
        return 14;
    endfunction

    always @(posedge aclk) if (seq_aborted === 1'b1) aborts++;

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [7:0] v;
        logic [3:0] mx;
        logic       s;
        int         src, nd, n;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {dedicated_trigger_inputs, analog_trig} = '0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        void'($urandom(9));
        rd(8'h00, 32'h0, OK);
        rd(8'h04, 32'h0, OK);
        rd(8'h10, 32'h0, ER);
        wr(8'h14, 32'hFF, ER);
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            v[6:5] = i[1:0];
            wr(8'h00, {25'h0, v[6:0]}, OK);
            wr(8'h04, {24'h0, v}, OK);
            rd(8'h00, {25'h0, v[6:0]}, OK);
            rd(8'h04, {24'h0, v}, OK);
            chk({28'h0, result_bits}, res_of(v[6:5]));
        end
        for (int i = 0; i < 32; i++) begin
            v = {i[4], 3'h0, i[3:0]};
            src = src_of(v);
            wr(8'h04, {24'h0, v}, OK);
            @(posedge aclk);
            {dedicated_trigger_inputs, analog_trig} <= ~(14'h1 << src);
            watch(s);
            chk({31'h0, s}, 32'h0);
            {dedicated_trigger_inputs, analog_trig} <= 14'h3FFF;
            watch(s);
            chk({31'h0, s}, {31'h0, src < 14});
            {dedicated_trigger_inputs, analog_trig} <= 14'h0;
        end
        wr(8'h04, 32'h0, OK);
        for (int i = 0; i < 2; i++) begin
            wr(8'h08, 32'h3, OK);
            repeat (2) @(posedge aclk);
            n = aborts;
            chk({31'h0, seq_busy}, 32'h1);
            wr({5'h0, i[0], 2'h0}, 32'h9, OK);
            repeat (2) @(posedge aclk);
            chk({31'h0, seq_busy}, 32'h0);
            chk(aborts, n + 1);
        end
        for (int i = 0; i < 4; i++) begin
            v = {4'h0, 4'(16'hF9A1 >> (4 * i))};
            wr(8'h00, {28'h0, v[3:0]}, OK);
            wr(8'h04, {27'h0, i[0], 4'h0}, OK);
            wr(8'h08, 32'h3, OK);
            mx = 4'h0;
            nd = 0;
            n = 0;
            do begin
                @(posedge aclk);
                n++;
                if (seq_busy === 1'b1 && cur_channel > mx) mx = cur_channel;
                if (discharging === 1'b1) nd++;
            end while (n < 1500 && !(n > 8 && seq_busy !== 1'b1)
                       && !(mx != 0 && cur_channel == 4'h0));
            if (n >= 1500) tmo();
            chk({28'h0, mx}, (v > 9) ? 32'h9 : {24'h0, v});
            chk({31'h0, nd != 0}, {31'h0, i[0]});
        end
        end_sim();
    end
endmodule // astc_top_test

bind astc_top astc_checker #(.HAS_DEDICATED(HAS_DEDICATED)) chk_i (.*);
